// ---- rtl/dps_defines.svh ----
`ifndef DPS_DEFINES_SVH
`define DPS_DEFINES_SVH
// ==========================================================
// Clock and timing
`define DPS_CLK_MHZ        125
`define DPS_TXSRD_CLK      200
`define DPS_TCKE_CLK       3
// ==========================================================
// Mode register selection and fields
`define DPS_MR_SEL_MR      3'h0
`define DPS_MR_SEL_EMR1    3'h1
`define DPS_MR_BL_LSB      0
`define DPS_MR_BL8_CODE    3'h3
`define DPS_EMR1_ODT_LO    2
`define DPS_EMR1_ODT_HI    6
`define DPS_EMR1_AL_LSB    3
`define DPS_AP_BIT         10
// ==========================================================
// Burst lengths in clocks, reset values and additive latency line depth
`define DPS_BURST_BL4      3'h2
`define DPS_BURST_BL8      3'h4
`define DPS_MR_RESET       15'h0000
`define DPS_AL_DEPTH       7
`endif

// ---- rtl/dps_pkg.sv ----
package dps_pkg;
   // ==========================================================
   // Decoded commands
   typedef enum logic [3:0] {
      DPS_C_NONE = 4'h0, DPS_C_MRS = 4'h1, DPS_C_REF = 4'h2,
      DPS_C_PRE  = 4'h3, DPS_C_ACT = 4'h4, DPS_C_WR  = 4'h5,
      DPS_C_RD   = 4'h6, DPS_C_BAD = 4'h7
   } dps_cmd_code_type;
   // ==========================================================
   // Power states
   typedef enum logic [4:0] {
      DPS_S_IDLE = 5'b00001, DPS_S_ACT = 5'b00010,
      DPS_S_PPD  = 5'b00100, DPS_S_APD = 5'b01000,
      DPS_S_SREF = 5'b10000
   } dps_state_type;
   // ==========================================================
   // Column command word handed to the array side
   typedef struct packed {
      logic       is_write;
      logic       auto_pre;
      logic [2:0] bank;
      logic [9:0] col;
   } dps_col_cmd_type;
endpackage : dps_pkg

// ---- rtl/dps_stream_if.sv ----
`timescale 1ns/1ps
interface dps_stream_if;
   import dps_pkg::*;
   logic            valid;
   logic            ready;
   dps_col_cmd_type data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : dps_stream_if

// ---- rtl/dps_buf.sv ----
`timescale 1ns/1ps
module dps_buf
   import dps_pkg::*;
(
   // Clock and reset
   input  wire logic clock_in,
   input  wire logic rst_n_in,
   // Streams
   dps_stream_if.snk up,
   dps_stream_if.src dn
);
   typedef struct packed {
      logic [1:0]      cnt;
      logic            vld;
      dps_col_cmd_type e0;
      dps_col_cmd_type e1;
   } dps_buf_st_type;
   dps_buf_st_type q, d;
   logic push, pop;
   always_comb begin
      d    = q;
      push = up.valid && (q.cnt != 2'h2);
      pop  = (q.cnt != 2'h0) && dn.ready;
      // Shift out the head, then append behind what remains
      if (pop) begin
         d.e0 = q.e1;
      end
      if (push) begin
         if (d.cnt - 2'(pop) == 2'h0) begin
            d.e0 = up.data;
         end else begin
            d.e1 = up.data;
         end
      end
      d.cnt = q.cnt + 2'(push) - 2'(pop);
      d.vld = (d.cnt != 2'h0);
   end
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
   assign up.ready = (q.cnt != 2'h2);
   assign dn.valid = q.vld;
   assign dn.data  = q.e0;
endmodule : dps_buf

// ---- rtl/dps_mode_mem.sv ----
`timescale 1ns/1ps
module dps_mode_mem #(
   parameter int WIDTH = 15,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input  wire logic                     clock_in,
   input  wire logic                     rst_n_in,
   // Write port
   input  wire logic                     wr_en_in,
   input  wire logic [$clog2(DEPTH)-1:0] wr_addr_in,
   input  wire logic [WIDTH-1:0]         wr_data_in,
   // Registered read port
   input  wire logic [$clog2(DEPTH)-1:0] rd_addr_in,
   output logic      [WIDTH-1:0]         rd_data_out
);
   logic [WIDTH-1:0] mem_q [DEPTH];
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_q[i] <= '0;
         end
         rd_data_out <= '0;
      end else begin
         if (wr_en_in) begin
            mem_q[wr_addr_in] <= wr_data_in;
         end
         rd_data_out <= mem_q[rd_addr_in];
      end
   end
endmodule : dps_mode_mem

// ---- rtl/dps_core.sv ----
`timescale 1ns/1ps
`include "dps_defines.svh"
// How it works
// - commands decode from CS, RAS, CAS, WE and CKE at each rising edge.
// - CKE fall with NOP enters active or precharge power-down.
// - no refresh happens during power-down; controller bounds its length.
// - termination off in self refresh; enabled ODT honoured in power-down.
// - data mask low writes the byte, high inhibits it.
// - chip select high registers no command; running work continues.
// - NOP registers no command and leaves running work alone.
// - MRS loads the register picked by bank address with address value.
// - ACTIVATE opens a row until precharge; no reopen without precharge.
// - READ bursts from the open row at column A0-A9; A10 is auto precharge.
// - auto precharge closes the row at burst end, else it stays open.
// - additive latency delays internal READ or WRITE registration.
module dps_core
   import dps_pkg::*;
#(
   parameter int TXSRD_CLK = `DPS_TXSRD_CLK,
   parameter int AW        = 15,
   parameter int NBYTES    = 2
) (
   // Clock and reset
   input  wire logic                  clock_in,
   input  wire logic                  rst_n_in,
   // Command pins
   input  wire logic                  cke_in,
   input  wire logic                  cs_n_in,
   input  wire logic                  ras_n_in,
   input  wire logic                  cas_n_in,
   input  wire logic                  we_n_in,
   input  wire logic [2:0]            ba_in,
   input  wire logic [AW-1:0]         addr_in,
   input  wire logic                  odt_in,
   // Write data beats
   input  wire logic                  wbeat_in,
   input  wire logic [8*NBYTES-1:0]   wdata_in,
   input  wire logic [NBYTES-1:0]     dm_in,
   // Column command stream
   input  wire logic                  col_ready_in,
   output logic                       col_valid_out,
   output dps_col_cmd_type            col_cmd_out,
   // Mode register readback
   input  wire logic [2:0]            mr_sel_in,
   output logic      [AW-1:0]         mr_data_out,
   // Status
   output dps_state_type              state_out,
   output logic      [7:0]            open_banks_out,
   output logic                       self_refresh_out,
   output logic                       odt_on_out,
   output logic                       read_block_out,
   output logic                       busy_out,
   output logic                       illegal_out,
   output logic                       overrun_out,
   // Array write strobes
   output logic      [NBYTES-1:0]     wr_strobe_out,
   output logic      [8*NBYTES-1:0]   wr_data_out
);
   // ==========================================================
   // Command decode
   function automatic dps_cmd_code_type decode(
      input logic cs_n, input logic ras_n,
      input logic cas_n, input logic we_n);
      logic [2:0] rcw;
      rcw = {ras_n, cas_n, we_n};
      if (cs_n) begin
         return DPS_C_NONE;
      end
      case (rcw)
         3'b111:  return DPS_C_NONE;
         3'b000:  return DPS_C_MRS;
         3'b001:  return DPS_C_REF;
         3'b010:  return DPS_C_PRE;
         3'b011:  return DPS_C_ACT;
         3'b100:  return DPS_C_WR;
         3'b101:  return DPS_C_RD;
         default: return DPS_C_BAD;
      endcase
   endfunction : decode

   // ==========================================================
   // State record
   typedef struct packed {
      dps_state_type                   st;
      logic                            cke_prev;
      logic [1:0]                      cke_hold;
      logic [7:0]                      open;
      logic [2:0]                      burst;
      logic                            burst_ap;
      logic [2:0]                      burst_bank;
      logic                            burst_wr;
      logic [1:0]                      mrd;
      logic [7:0]                      xsrd;
      logic [AW-1:0]                   mr;
      logic [AW-1:0]                   emr1;
      logic [`DPS_AL_DEPTH-1:0]        al_vld;
      dps_col_cmd_type [`DPS_AL_DEPTH-1:0] al_cmd;
      logic                            illegal;
      logic                            overrun;
      logic                            odt_on;
      logic                            sref;
      logic                            rblk;
      logic                            busy;
      logic [NBYTES-1:0]               strobe;
      logic [8*NBYTES-1:0]             wdata;
   } dps_core_st_type;

   dps_core_st_type  q, d;
   dps_cmd_code_type cmd;
   dps_col_cmd_type  cword;
   logic             busy;
   logic             cke_edge;
   logic [2:0]       al;
   logic             mr_wr;

   dps_stream_if al_if ();
   dps_stream_if out_if ();

   always_comb begin
      d        = q;
      cmd      = decode(cs_n_in, ras_n_in, cas_n_in, we_n_in);
      cword    = '{is_write: (cmd == DPS_C_WR),
                   auto_pre: addr_in[`DPS_AP_BIT],
                   bank:     ba_in,
                   col:      addr_in[9:0]};
      busy     = (q.burst != 3'h0) || (q.mrd != 2'h0);
      cke_edge = (cke_in != q.cke_prev);
      al       = q.emr1[`DPS_EMR1_AL_LSB +: 3];
      mr_wr    = 1'b0;
      d.cke_prev = cke_in;

      // CKE minimum hold of three registered edges
      if (cke_edge) begin
         if (q.cke_hold != 2'h0) begin
            d.illegal = 1'b1;
         end
         d.cke_hold = 2'(`DPS_TCKE_CLK - 1);
      end else if (q.cke_hold != 2'h0) begin
         d.cke_hold = q.cke_hold - 2'h1;
      end

      // Self refresh exit read lockout
      if (q.xsrd != 8'h0) begin
         d.xsrd = q.xsrd - 8'h1;
      end
      if (q.mrd != 2'h0) begin
         d.mrd = q.mrd - 2'h1;
      end

      // Burst progress and auto precharge at its end
      if (q.burst != 3'h0) begin
         d.burst = q.burst - 3'h1;
         if (q.burst == 3'h1 && q.burst_ap) begin
            d.open[q.burst_bank] = 1'b0;
         end
      end

      // Additive latency line shifts toward the buffer
      d.al_vld = q.al_vld >> 1;
      d.al_cmd = q.al_cmd >> $bits(dps_col_cmd_type);
      if (q.al_vld[0] && !al_if.ready) begin
         d.overrun = 1'b1;
      end
      if (q.al_vld[0] && !q.al_cmd[0].is_write) begin
         d.burst      = (q.mr[`DPS_MR_BL_LSB +: 3] == `DPS_MR_BL8_CODE)
                        ? `DPS_BURST_BL8 : `DPS_BURST_BL4;
         d.burst_ap   = q.al_cmd[0].auto_pre;
         d.burst_bank = q.al_cmd[0].bank;
         d.burst_wr   = 1'b0;
      end else if (q.al_vld[0]) begin
         d.burst      = (q.mr[`DPS_MR_BL_LSB +: 3] == `DPS_MR_BL8_CODE)
                        ? `DPS_BURST_BL8 : `DPS_BURST_BL4;
         d.burst_ap   = q.al_cmd[0].auto_pre;
         d.burst_bank = q.al_cmd[0].bank;
         d.burst_wr   = 1'b1;
      end

      case (q.st)
         DPS_S_PPD, DPS_S_APD: begin
            if (cke_in) begin
               if (cmd != DPS_C_NONE) begin
                  d.illegal = 1'b1;
               end
               d.st = (q.open != 8'h0) ? DPS_S_ACT : DPS_S_IDLE;
            end
         end
         DPS_S_SREF: begin
            if (cke_in) begin
               if (cmd != DPS_C_NONE) begin
                  d.illegal = 1'b1;
               end
               d.st   = DPS_S_IDLE;
               d.xsrd = 8'(TXSRD_CLK - 1);
            end
         end
         DPS_S_IDLE, DPS_S_ACT: begin
            if (!cke_in) begin
               if (busy) begin
                  d.illegal = 1'b1;
               end
               if (cmd == DPS_C_NONE) begin
                  d.st = (q.open != 8'h0) ? DPS_S_APD : DPS_S_PPD;
               end else if (cmd == DPS_C_REF && q.open == 8'h0) begin
                  d.st = DPS_S_SREF;
               end else begin
                  d.illegal = 1'b1;
               end
            end else if (q.xsrd != 8'h0 && q.xsrd == 8'(TXSRD_CLK - 1)
                         && cmd != DPS_C_NONE) begin
               d.illegal = 1'b1;
            end else begin
               case (cmd)
                  DPS_C_MRS: begin
                     if (q.open != 8'h0) begin
                        d.illegal = 1'b1;
                     end
                     mr_wr = 1'b1;
                     d.mrd = 2'h2;
                     if (ba_in == `DPS_MR_SEL_MR) begin
                        d.mr = addr_in;
                     end
                     if (ba_in == `DPS_MR_SEL_EMR1) begin
                        d.emr1 = addr_in;
                     end
                  end
                  DPS_C_ACT: begin
                     if (q.open[ba_in]) begin
                        d.illegal = 1'b1;
                     end
                     d.open[ba_in] = 1'b1;
                  end
                  DPS_C_PRE: begin
                     if (addr_in[`DPS_AP_BIT]) begin
                        d.open = 8'h0;
                     end else begin
                        d.open[ba_in] = 1'b0;
                     end
                  end
                  DPS_C_RD, DPS_C_WR: begin
                     if (cmd == DPS_C_RD && q.xsrd != 8'h0) begin
                        d.illegal = 1'b1;
                     end
                     d.al_vld[al] = 1'b1;
                     d.al_cmd[al] = cword;
                  end
                  DPS_C_BAD: d.illegal = 1'b1;
                  default: ;
               endcase
               d.st = (d.open != 8'h0) ? DPS_S_ACT : DPS_S_IDLE;
            end
         end
         default: d.st = DPS_S_IDLE;
      endcase

      // Termination follows the pin when EMR1 enables ODT, except in self refresh
      d.odt_on = odt_in && (d.st != DPS_S_SREF)
                 && (q.emr1[`DPS_EMR1_ODT_LO]
                     || q.emr1[`DPS_EMR1_ODT_HI]);
      // Registered status decodes
      d.sref   = (d.st == DPS_S_SREF);
      d.rblk   = (d.xsrd != 8'h0);
      d.busy   = (d.burst != 3'h0) || (d.mrd != 2'h0);

      // Byte strobes for write beats
      d.strobe = (wbeat_in && q.burst != 3'h0 && q.burst_wr)
                 ? ~dm_in : '0;
      d.wdata  = wdata_in;
   end

   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         q          <= '0;
         q.st       <= DPS_S_IDLE;
         q.cke_prev <= 1'b1;
         q.mr       <= `DPS_MR_RESET;
         q.emr1     <= `DPS_MR_RESET;
      end else begin
         q <= d;
      end
   end

   // ==========================================================
   // Buffer between latency line and array side
   assign al_if.valid   = q.al_vld[0];
   assign al_if.data    = q.al_cmd[0];
   assign out_if.ready  = col_ready_in;

   dps_buf u_buf (
      .clock_in (clock_in),
      .rst_n_in (rst_n_in),
      .up       (al_if),
      .dn       (out_if)
   );

   dps_mode_mem #(.WIDTH(AW), .DEPTH(8)) u_mem (
      .clock_in    (clock_in),
      .rst_n_in    (rst_n_in),
      .wr_en_in    (mr_wr),
      .wr_addr_in  (ba_in),
      .wr_data_in  (addr_in),
      .rd_addr_in  (mr_sel_in),
      .rd_data_out (mr_data_out)
   );

   // ==========================================================
   // Outputs
   assign col_valid_out    = out_if.valid;
   assign col_cmd_out      = out_if.data;
   assign state_out        = q.st;
   assign open_banks_out   = q.open;
   assign self_refresh_out = q.sref;
   assign odt_on_out       = q.odt_on;
   assign read_block_out   = q.rblk;
   assign busy_out         = q.busy;
   assign illegal_out      = q.illegal;
   assign overrun_out      = q.overrun;
   assign wr_strobe_out    = q.strobe;
   assign wr_data_out      = q.wdata;
endmodule : dps_core

// ---- tb/dps_core_monitor.sv ----
`timescale 1ns/1ps
module dps_core_monitor
   import dps_pkg::*;
#(
   parameter int AW     = 15,
   parameter int NBYTES = 2
) (
   // Clock and pins
   input wire logic              clock_in,
   input wire logic              rst_n_in,
   input wire logic              cke_in,
   input wire logic              cs_n_in,
   input wire logic              ras_n_in,
   input wire logic              cas_n_in,
   input wire logic              we_n_in,
   input wire logic [2:0]        ba_in,
   input wire logic [AW-1:0]     addr_in,
   input wire logic              wbeat_in,
   input wire logic [NBYTES-1:0] dm_in,
   input wire logic              col_ready_in,
   input wire logic [2:0]        mr_sel_in,
   // Outputs
   input wire logic              col_valid_out,
   input wire dps_col_cmd_type   col_cmd_out,
   input wire logic [AW-1:0]     mr_data_out,
   input wire dps_state_type     state_out,
   input wire logic [7:0]        open_banks_out,
   input wire logic              self_refresh_out,
   input wire logic              read_block_out,
   input wire logic              busy_out,
   input wire logic              illegal_out,
   input wire logic [NBYTES-1:0] wr_strobe_out
);
   // ==========================================================
   // Helpers
   logic       cke_p_q;
   logic [1:0] since_q;
   wire        nop = cs_n_in | (ras_n_in & cas_n_in & we_n_in);
   wire        hh  = cke_p_q & cke_in;
   wire        fall = cke_p_q & ~cke_in & since_q[1] & ~busy_out;
   wire        lo  = ~cs_n_in & ~ras_n_in;
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         cke_p_q <= 1'b1;
         since_q <= 2'h3;
      end else begin
         cke_p_q <= cke_in;
         if (cke_in != cke_p_q) since_q <= 2'h0;
         else if (since_q != 2'h3) since_q <= since_q + 2'h1;
      end
   end
   default clocking @(posedge clock_in); endclocking
   default disable iff (!rst_n_in);
   // ==========================================================
   // Assertions
   a_act_open_bank: assert property (
      (hh && lo && cas_n_in && we_n_in) |=> open_banks_out[$past(ba_in)])
      else $error("activate left bank closed");
   a_pd_entry_kind: assert property (
      (fall && nop && (state_out == DPS_S_IDLE || state_out == DPS_S_ACT))
      |=> state_out == ($past(open_banks_out) != 8'h00 ? DPS_S_APD
                                                      : DPS_S_PPD))
      else $error("wrong power-down kind");
   a_pd_hold_state: assert property (
      ((state_out == DPS_S_APD || state_out == DPS_S_PPD) && !cke_in)
      |=> $stable(state_out)) else $error("power-down not held");
   a_sref_entry_go: assert property (
      (fall && lo && !cas_n_in && we_n_in && state_out == DPS_S_IDLE)
      |=> state_out == DPS_S_SREF && self_refresh_out)
      else $error("self refresh not entered");
   a_sref_exit_lock: assert property (
      (state_out == DPS_S_SREF && cke_in && !cke_p_q && nop)
      |=> read_block_out ##1 read_block_out)
      else $error("read lockout missing");
   a_cke_short_flag: assert property (
      (cke_in != cke_p_q && !since_q[1]) |=> illegal_out)
      else $error("short cke pulse not flagged");
   a_illegal_sticky: assert property (
      illegal_out |=> illegal_out) else $error("illegal flag dropped");
   a_mask_strobe: assert property (
      (wr_strobe_out != '0) |-> $past(wbeat_in) &&
      (wr_strobe_out & $past(dm_in)) == '0)
      else $error("masked byte strobed");
   a_deselect_quiet: assert property (
      (hh && cs_n_in && !busy_out && !col_valid_out)
      |=> open_banks_out == $past(open_banks_out))
      else $error("deselect changed banks");
   a_mrs_readback: assert property (
      (hh && lo && !cas_n_in && !we_n_in && state_out == DPS_S_IDLE)
      ##1 (mr_sel_in == $past(ba_in))
      |=> mr_data_out == $past(addr_in, 2))
      else $error("mode register not loaded");
   a_col_word_hold: assert property (
      (col_valid_out && !col_ready_in) |=> col_valid_out &&
      $stable(col_cmd_out)) else $error("column word not held");
endmodule : dps_core_monitor
bind dps_core dps_core_monitor #(.AW(AW), .NBYTES(NBYTES)) mon_inst (
   .clock_in(clock_in), .rst_n_in(rst_n_in), .cke_in(cke_in),
   .cs_n_in(cs_n_in), .ras_n_in(ras_n_in), .cas_n_in(cas_n_in),
   .we_n_in(we_n_in), .ba_in(ba_in), .addr_in(addr_in),
   .wbeat_in(wbeat_in), .dm_in(dm_in), .col_ready_in(col_ready_in),
   .mr_sel_in(mr_sel_in), .col_valid_out(col_valid_out),
   .col_cmd_out(col_cmd_out), .mr_data_out(mr_data_out),
   .state_out(state_out), .open_banks_out(open_banks_out),
   .self_refresh_out(self_refresh_out), .read_block_out(read_block_out),
   .busy_out(busy_out), .illegal_out(illegal_out),
   .wr_strobe_out(wr_strobe_out));

// ---- tb/dps_ctl_model.sv ----
`timescale 1ns/1ps
module dps_ctl_model (
   // Clock and requests
   input  wire logic       clock_in,
   input  wire logic [2:0] op_in,
   input  wire logic [1:0] mode_in,
   // Pins cs_n, ras_n, cas_n, we_n and ready
   output logic      [3:0] pins_out,
   output logic            ready_out
);
   logic [7:0] pat_q = 8'h5A;
   always @(posedge clock_in) begin
      pat_q <= #1 {pat_q[6:0], pat_q[7] ^ pat_q[5] ^ pat_q[4] ^ pat_q[3]};
   end
   // ==========================================================
   // Command encoding, deselect leaves other pins moving
   always_comb begin
      case (op_in)
         3'h0: pins_out = {1'b1, pat_q[2:0]};
         3'h1: pins_out = 4'h7;
         3'h2: pins_out = 4'h0;
         3'h3: pins_out = 4'h1;
         3'h4: pins_out = 4'h2;
         3'h5: pins_out = 4'h3;
         3'h6: pins_out = 4'h4;
         default: pins_out = 4'h5;
      endcase
   end
   // Mode 0 ready, 1 random stalls, 2 stalled
   assign ready_out = (mode_in == 2'h0) | ((mode_in == 2'h1) & pat_q[0]);
endmodule : dps_ctl_model

// ---- tb/tb.sv ----
`timescale 1ns/1ps
module tb;
   import dps_pkg::*;
   localparam int TX = 5;
   logic            clock_in, rst_n_in, cke, odt, wbeat, col_ready;
   logic [2:0]      op, ba, mr_sel;
   logic [1:0]      mode, dm, strobe;
   logic [14:0]     addr, mr_data;
   logic [15:0]     wdata, wr_data;
   logic [3:0]      pins;
   logic            ok, odt_en = 1'b0;
   logic [7:0]      banks;
   logic            col_valid, sref, odt_on, rblk, busy, illegal, overrun;
   logic [31:0]     r;
   dps_col_cmd_type col_cmd;
   dps_state_type   state;
   dps_col_cmd_type exp_q[$];
   int              miscompares = 0, check_count = 0, seed = 93, n;
   dps_core #(.TXSRD_CLK(TX)) dps_core_inst (
      .clock_in(clock_in), .rst_n_in(rst_n_in), .cke_in(cke),
      .cs_n_in(pins[3]), .ras_n_in(pins[2]), .cas_n_in(pins[1]),
      .we_n_in(pins[0]), .ba_in(ba), .addr_in(addr), .odt_in(odt),
      .wbeat_in(wbeat), .wdata_in(wdata), .dm_in(dm),
      .col_ready_in(col_ready), .col_valid_out(col_valid),
      .col_cmd_out(col_cmd), .mr_sel_in(mr_sel), .mr_data_out(mr_data),
      .state_out(state), .open_banks_out(banks), .self_refresh_out(sref),
      .odt_on_out(odt_on), .read_block_out(rblk), .busy_out(busy),
      .illegal_out(illegal), .overrun_out(overrun),
      .wr_strobe_out(strobe), .wr_data_out(wr_data));
   dps_ctl_model dps_ctl_model_inst (.clock_in(clock_in), .op_in(op),
      .mode_in(mode), .pins_out(pins), .ready_out(col_ready));
   initial begin
      clock_in = 1'b0;
      forever #4 clock_in = ~clock_in;
   end
   // ==========================================================
   // Tasks
   task check(input string name, input logic [31:0] seen, exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task test_done;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : test_done
   task cyc(input logic [2:0] o, b, input logic [14:0] a, input logic k);
      op = o;
      ba = b;
      addr = (o < 3'h2) ? 15'($random(seed)) : a;
      cke = k;
      @(posedge clock_in);
      #1;
   endtask : cyc
   task nops(input int c, input logic k);
      repeat (c) cyc(3'h1, 3'h0, 15'h0000, k);
   endtask : nops
   task col(input logic [2:0] o, b, input logic [14:0] a);
      exp_q.push_back(dps_col_cmd_type'({o == 3'h6, a[10], b, a[9:0]}));
      cyc(o, b, a, 1'b1);
   endtask : col
   // ==========================================================
   // Write beats and termination, random
   always @(posedge clock_in) begin
      ok = rst_n_in;
      #1;
      if (ok === 1'b1) check("wdata", wr_data, wdata);
      if (odt_en === 1'b1)
         check("odt_on", odt_on, odt && state != DPS_S_SREF);
      r = $random(seed);
      {wbeat, odt, dm} = r[3:0];
      wdata = r[31:16];
   end
   // Column word scoreboard
   always @(posedge clock_in) begin
      if (col_valid === 1'b1 && col_ready === 1'b1) begin
         if (exp_q.size() == 0) check("col_extra", 1, 0);
         else check("col_cmd", col_cmd, exp_q.pop_front());
      end
   end
   initial begin
      #300000;
      miscompares++;
      test_done();
   end
   // ==========================================================
   // Main sequence
   initial begin
      {rst_n_in, op, ba, addr, cke, mode, mr_sel} = 0;
      {wbeat, odt, dm, wdata} = 0;
      cke = 1'b1;
      repeat (3) @(posedge clock_in);
      #1;
      rst_n_in = 1'b1;
      cyc(3'h2, 3'h0, 15'h0003, 1'b1);
      nops(3, 1'b1);
      cyc(3'h2, 3'h1, 15'h0004, 1'b1);
      nops(3, 1'b1);
      odt_en = 1'b1;
      nops(2, 1'b1);
      check("mr0", mr_data, 15'h0003);
      mr_sel = 3'h1;
      nops(2, 1'b1);
      check("mr1", mr_data, 15'h0004);
      $display("test mode registers done");
      cyc(3'h5, 3'h2, 15'($random(seed)), 1'b1);
      check("bank2", banks[2], 1'b1);
      check("active", state, DPS_S_ACT);
      mode = 2'h2;
      repeat (2) col(3'h7, 3'h2, {5'h00, 10'($random(seed))});
      nops(10, 1'b1);
      check("overrun", overrun, 1'b0);
      mode = 2'h1;
      nops(20, 1'b1);
      check("row_kept", banks[2], 1'b1);
      col(3'h6, 3'h2, {5'h01, 10'($random(seed))});
      nops(20, 1'b1);
      check("row_closed", banks[2], 1'b0);
      $display("test column commands done");
      cyc(3'h5, 3'h2, 15'h0011, 1'b1);
      cyc(3'h5, 3'h5, 15'h0022, 1'b1);
      for (int i = 0; i < 6; i++) cyc(3'(i & 1), 3'h0, 15'h0000, 1'b1);
      check("banks", banks, 8'h24);
      cyc(3'h1, 3'h0, 15'h0000, 1'b0);
      check("apd", state, DPS_S_APD);
      for (int i = 0; i < 4; i++) cyc(3'($random(seed)), 3'h0, 15'h0, 1'b0);
      check("apd_hold", state, DPS_S_APD);
      cyc(3'h1, 3'h0, 15'h0000, 1'b1);
      nops(3, 1'b1);
      cyc(3'h4, 3'h0, 15'h0400, 1'b1);
      nops(3, 1'b1);
      check("idle", banks, 8'h00);
      cyc(3'h1, 3'h0, 15'h0000, 1'b0);
      check("ppd", state, DPS_S_PPD);
      nops(3, 1'b0);
      cyc(3'h1, 3'h0, 15'h0000, 1'b1);
      nops(3, 1'b1);
      $display("test power-down done");
      cyc(3'h3, 3'h0, 15'h0000, 1'b0);
      check("sref", {state, sref}, {DPS_S_SREF, 1'b1});
      nops(4, 1'b0);
      cyc(3'h1, 3'h0, 15'h0000, 1'b1);
      n = 0;
      while (rblk === 1'b1 && n < 300) begin
         nops(1, 1'b1);
         n++;
      end
      if (n == 300) begin
         miscompares++;
         test_done();
      end
      check("lockout", n, TX - 1);
      check("legal", illegal, 1'b0);
      $display("test self refresh done");
      nops(3, 1'b1);
      cyc(3'h1, 3'h0, 15'h0000, 1'b0);
      cyc(3'h1, 3'h0, 15'h0000, 1'b1);
      nops(2, 1'b1);
      check("illegal", illegal, 1'b1);
      n = 0;
      while (exp_q.size() != 0 && n < 100) begin
         nops(1, 1'b1);
         n++;
      end
      check("drained", exp_q.size(), 0);
      $display("test illegal sequence done");
      test_done();
   end
endmodule : tb
